/* File: dv/gpio_port_pin_mux_remap_test.sv */
// self-checking bench for the gpio port block with pin mux and remap
module gpio_port_pin_mux_remap_test import gpm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, ext_irq_level, timer0_ext_input, timer1_ext_input, wake_req;
    logic [47:0] pin_in, pin_out, pin_oe, pin_pullup, pin_analog;
    logic [47:0] ext_drv = '1;
    logic [47:0] ext_en = '0;
    logic        irq_ctrl_en = 1'b0;
    logic        timer0_count_mode = 1'b0;
    logic        timer1_count_mode = 1'b0;
    logic        freq_divider_src = 1'b0;
    logic        pwm0_src = 1'b0;
    logic        pwm1_src = 1'b0;
    logic        lcd_bias_phase = 1'b0;
    logic        sleep_mode = 1'b0;
    logic [31:0] exp_q[$];
    logic        err_seen = 1'b0;
    int          err_total = 0;
    int          tests_run = 0;
    // pin index per slot (divider, timer0, irq, timer1) and remap value
    int          fpin[4][4] = '{'{1, 21, 8, 32}, '{2, 20, 9, 33}, '{3, 19, 10, 34}, '{4, 18, 11, 35}};

    gpm_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup, .pin_analog, .irq_ctrl_en,
        .ext_irq_level, .timer0_count_mode, .timer1_count_mode, .timer0_ext_input,
        .timer1_ext_input, .freq_divider_src, .pwm0_src, .pwm1_src, .lcd_bias_phase,
        .sleep_mode, .wake_req);
    gpm_pins_model u_pins (.pclk, .pin_out, .pin_oe, .pin_pullup, .ext_drv, .ext_en, .pin_in);

    always #50 pclk = ~pclk;

    // --------------
    // tasks and checks
    // --------------
    function automatic logic [31:0] z(input logic [7:0] v);
        return {24'h0, v};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic drv(input logic [47:0] d, input logic [47:0] e);
        @(posedge pclk);
        ext_drv <= d;
        ext_en <= e;
    endtask
    task automatic settle();
        repeat (4) @(posedge pclk);
        #1;
    endtask
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1)
            err_seen <= pslverr;
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
            chk(prdata, exp_q.pop_front());
    end
    initial begin
        repeat (6000) @(posedge pclk);
        err_total++;
        test_done();
    end

    initial begin
        logic [7:0]  d, m, x;
        logic [47:0] v;
        int          n;
        void'($urandom(58));
        do_reset();
        settle();
        chk({31'h0, |{pin_oe, pin_pullup, pin_analog}}, 32'h0);
        for (int p = 0; p < NPORT; p++) begin
            rd(G_DIR + 12'(4 * p), 32'hff);
            rd(G_PU + 12'(4 * p), 32'h0);
        end
        rd(A_WAKEA, 32'h0);
        rd(A_REMAP, 32'h0);
        rd(12'h0c0, 32'h0);
        #1;
        chk(z({7'h0, err_seen}), 32'h1);
        rd(A_PINS, 32'h0);
        #1;
        chk(z({7'h0, err_seen}), 32'h0);
        for (int p = 0; p < NPORT; p++) begin
            d = 8'($urandom());
            m = 8'($urandom());
            x = 8'($urandom());
            drv({40'h0, x} << (8 * p), {40'h0, m} << (8 * p));
            wr(G_DIR + 12'(4 * p), z(m));
            settle();
            chk(z(pin_oe[p*8+:8]), z(~m));
            chk(z(pin_out[p*8+:8] & ~m), z(~m));
            wr(G_DATA + 12'(4 * p), z(d));
            settle();
            chk(z(pin_out[p*8+:8] & ~m), z(d & ~m));
            rd(G_DATA + 12'(4 * p), z((d & ~m) | (x & m)));
        end
        drv(48'h0000_00a0_0000, 48'h0000_00f0_0000);
        wr(G_DIR + 12'h8, 32'hf0);
        wr(G_DATA + 12'h8, 32'h05);
        wr(G_BSET + 12'h8, 32'h02);
        wr(G_DIR + 12'h8, 32'h00);
        settle();
        chk(z(pin_out[23:16]), 32'ha7);
        wr(G_BCLR + 12'h8, 32'h04);
        rd(G_DATA + 12'h8, 32'ha3);
        wr(G_PU, 32'hff);
        wr(G_DIR, 32'h8f);
        wr(G_PU + 12'h4, 32'hff);
        wr(G_DIR + 12'h4, 32'hff);
        wr(A_ANSEL, 32'h0f);
        settle();
        chk({pin_analog[15:8], pin_pullup[15:0]}, 32'h0f_f0_0f);
        do_reset();
        irq_ctrl_en <= 1'b1;
        timer0_count_mode <= 1'b1;
        timer1_count_mode <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(A_REMAP, 32'(k));
            for (int s = 0; s < 2; s++) begin
                v = '1;
                for (int j = 1; j < 4; j++) v[fpin[j][k]] = s[0];
                drv(v, '1);
                settle();
                chk(z({5'h0, ext_irq_level, timer1_ext_input, timer0_ext_input}), z({5'h0, {3{s[0]}}}));
            end
            n = fpin[0][k];
            wr(A_FSEL, 32'h1);
            drv('1, ~(48'h1 << n));
            wr(G_DIR + 12'(4 * (n / 8)), z(~(8'h1 << (n % 8)) & ~(8'h1 << (fpin[2][k] % 8))));
            for (int s = 0; s < 2; s++) begin
                @(posedge pclk);
                freq_divider_src <= s[0];
                settle();
                chk(z({6'h0, ext_irq_level, pin_out[n]}), z({7'h0, s[0]}));
            end
            wr(G_DIR + 12'(4 * (n / 8)), 32'hff);
            settle();
            chk(z({7'h0, pin_oe[n]}), 32'h0);
        end
        drv('1, '1);
        irq_ctrl_en <= 1'b0;
        timer0_count_mode <= 1'b0;
        settle();
        chk(z({6'h0, ext_irq_level, timer0_ext_input}), 32'h0);
        wr(A_FSEL, 32'h6);
        wr(G_DIR + 12'hc, 32'hfc);
        for (int s = 0; s < 2; s++) begin
            @(posedge pclk);
            pwm0_src <= s[0];
            pwm1_src <= ~s[0];
            settle();
            chk(z({6'h0, pin_out[25:24]}), z({6'h0, ~s[0], s[0]}));
        end
        wr(G_DIR + 12'hc, 32'hff);
        settle();
        chk(z({6'h0, pin_oe[25:24]}), 32'h0);
        wr(A_LCD, 32'hf);
        for (int s = 0; s < 2; s++) begin
            @(posedge pclk);
            lcd_bias_phase <= s[0];
            settle();
            chk(z({pin_oe[11:8], pin_out[11:8]}), z({4'hf, {4{s[0]}}}));
        end
        wr(A_WAKEA, 32'h1);
        @(posedge pclk);
        sleep_mode <= 1'b1;
        drv(~48'h1, '1);
        n = 0;
        while (wake_req !== 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        sleep_mode <= 1'b0;
        chk(z({7'h0, wake_req}), 32'h1);
        rd(A_STAT, 32'h1);
        wr(A_STAT, 32'h1);
        rd(A_STAT, 32'h0);
        sleep_mode <= 1'b1;
        drv(~48'h3, '1);
        settle();
        chk(z({7'h0, wake_req}), 32'h0);
        wr(A_WAKEC, 32'h1);
        drv(~48'h1_0003, '1);
        settle();
        chk(z({7'h0, wake_req}), 32'h1);
        test_done();
    end
endmodule

/* File: dv/gpm_pins_model.sv */
// external circuitry on the port pins: bench sources, pull-highs and floating lines
module gpm_pins_model (
    input  wire logic        pclk,
    input  wire logic [47:0] pin_out,
    input  wire logic [47:0] pin_oe,
    input  wire logic [47:0] pin_pullup,
    input  wire logic [47:0] ext_drv,
    input  wire logic [47:0] ext_en,
    output logic      [47:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [47:0] last_r = '0;
    // a line nobody drives or pulls high toggles every cycle, so a stale read never matches by luck
    always_ff @(posedge pclk) begin
        last_r <= pin_in;
    end
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv)
                  | (~pin_oe & ~ext_en & (pin_pullup | ~last_r));
endmodule

/* File: dv/gpm_port_props.sv */
// assertion checker for the gpio port block, bound to its top module
module gpm_port_props
    import gpm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pslverr,
    input wire logic [47:0]       pin_oe,
    input wire logic [47:0]       pin_pullup,
    input wire logic [47:0]       pin_analog,
    input wire logic              irq_ctrl_en,
    input wire logic              ext_irq_level,
    input wire logic              timer0_count_mode,
    input wire logic              timer1_count_mode,
    input wire logic              timer0_ext_input,
    input wire logic              timer1_ext_input,
    input wire logic              sleep_mode,
    input wire logic              wake_req
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------
    // bus and pins
    // ------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic clr_w;
    // only a write of one to the status flag may drop a pending wake
    assign clr_w = psel && penable && pwrite && paddr[11:0] == A_STAT && pwdata[ST_WAKE];
    err_in_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    unmapped_err_a: assert property (psel && penable && paddr[11:0] > A_PINS |-> pslverr)
        else $error("unmapped access not refused");
    pa7_no_pull_a: assert property (!pin_pullup[7]) else $error("pull on port a bit 7");
    pull_input_a: assert property ((pin_pullup & pin_oe) == '0) else $error("pull on output");
    analog_no_pull_a: assert property ((pin_pullup & pin_analog) == '0) else $error("pull on analog");
    irq_gated_a: assert property (ext_irq_level |-> irq_ctrl_en) else $error("irq not gated");
    timer_gated_a: assert property ((timer0_ext_input |-> timer0_count_mode) and
        (timer1_ext_input |-> timer1_count_mode)) else $error("timer input not gated");
    wake_in_sleep_a: assert property ($rose(wake_req) |-> $past(sleep_mode))
        else $error("wake outside sleep");
    wake_sticky_a: assert property (wake_req && !clr_w |=> wake_req) else $error("wake lost");
    cover property ($rose(wake_req));
    cover property (pslverr);
    cover property (ext_irq_level ##1 !ext_irq_level);
endmodule

bind gpm_port gpm_port_props #(.ADDR_W(ADDR_W)) u_props (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pslverr, .pin_oe, .pin_pullup, .pin_analog, .irq_ctrl_en,
    .ext_irq_level, .timer0_count_mode, .timer1_count_mode, .timer0_ext_input,
    .timer1_ext_input, .sleep_mode, .wake_req);

/* File: hdl/gpm_pkg.sv */
// constants and types for the gpio port block with pin mux and remap
// ---------------------------------------------------------------
// Functional notes
// RL1 - direction 1: input, read live pin
// RL2 - direction 0: push-pull drive from latch
// RL3 - output pin read returns latch content
// RL4 - interrupt needs PA3-slot input and controller enable
// RL5 - interrupt pin keeps normal I/O behaviour
// RL6 - timer input needs count/capture mode, input direction
// RL7 - timer pin keeps I/O and pull-high
// RL8 - divider output only when selected and output
// RL9 - PWM output only when selected and output
// RL10 - LCD common drives PB0-3 half-bias
// RL11 - analog select disconnects pull-high
// RL12 - remap field resets to zero
// RL13 - remap 00 PA1-4, 01 PC5-2
// RL14 - remap 10 PB0-3, 11 PE0-3
// RL15 - remap independent of function select
// RL16 - data and direction reset to ones
// RL17 - bit set/clear is read-modify-write
// RL18 - falling edge on enabled PA/PC wakes
// RL19 - wake and pull enables reset to zero
// RL20 - pull-high only on inputs, never PA7
// RL21 - unmapped pins plain I/O, function from mapped pin
// RL22 - pin inputs synchronised before use
// ---------------------------------------------------------------
package gpm_pkg;
    localparam int NPORT = 6;
    localparam int PW    = 8;
    // port indices
    localparam logic [2:0] P_A = 3'h0;
    localparam logic [2:0] P_B = 3'h1;
    localparam logic [2:0] P_C = 3'h2;
    localparam logic [2:0] P_E = 3'h4;
    // register groups: offset = group*0x20 + port*4
    localparam logic [11:0] G_DATA  = 12'h000;
    localparam logic [11:0] G_DIR   = 12'h020;
    localparam logic [11:0] G_PU    = 12'h040;
    localparam logic [11:0] G_BSET  = 12'h060;
    localparam logic [11:0] G_BCLR  = 12'h080;
    localparam logic [11:0] A_WAKEA = 12'h0a0;
    localparam logic [11:0] A_WAKEC = 12'h0a4;
    localparam logic [11:0] A_FSEL  = 12'h0a8;
    localparam logic [11:0] A_REMAP = 12'h0ac;
    localparam logic [11:0] A_LCD   = 12'h0b0;
    localparam logic [11:0] A_ANSEL = 12'h0b4;
    localparam logic [11:0] A_STAT  = 12'h0b8;
    localparam logic [11:0] A_PINS  = 12'h0bc;
    localparam logic [11:0] GRP_MSK = 12'hfe0;
    // reset values
    localparam logic [7:0] RST_ONES = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [1:0] RST_MAP  = 2'h0;
    localparam logic [7:0] PU_MASK_A = 8'h7f;
    // function select bits
    localparam int FS_PFD  = 0;
    localparam int FS_PWM0 = 1;
    localparam int FS_PWM1 = 2;
    // status bits
    localparam int ST_WAKE = 0;
    // remap slots: divider, timer0, interrupt, timer1
    typedef enum logic [1:0] {
        GPM_MAP_A = 2'h0,
        GPM_MAP_C = 2'h1,
        GPM_MAP_B = 2'h2,
        GPM_MAP_E = 2'h3
    } gpm_map_t;
    // fixed pwm pins: port d bits 0 and 1
    localparam logic [2:0] P_PWM = 3'h3;
    localparam int PWM0_BIT = 0;
    localparam int PWM1_BIT = 1;
    // analog inputs on port b bits 0..7
    localparam logic [2:0] P_AN = 3'h1;
endpackage

/* File: hdl/gpm_port.sv */
// gpio ports with direction, pull-high, wake-up, function mux and remap
//
// The APB slave port and the register offsets were chosen for this implementation.
module gpm_port
    import gpm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [NPORT*PW-1:0] pin_in,
    output logic      [NPORT*PW-1:0] pin_out,
    output logic      [NPORT*PW-1:0] pin_oe,
    output logic      [NPORT*PW-1:0] pin_pullup,
    output logic      [NPORT*PW-1:0] pin_analog,
    input  wire logic                irq_ctrl_en,
    output logic                     ext_irq_level,
    input  wire logic                timer0_count_mode,
    input  wire logic                timer1_count_mode,
    output logic                     timer0_ext_input,
    output logic                     timer1_ext_input,
    input  wire logic                freq_divider_src,
    input  wire logic                pwm0_src,
    input  wire logic                pwm1_src,
    input  wire logic                lcd_bias_phase,
    input  wire logic                sleep_mode,
    output logic                     wake_req
);
    initial begin
        if (ADDR_W < 12) $error("gpm_port: ADDR_W must be at least 12");
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [PW-1:0] data_r   [NPORT];
    logic [PW-1:0] dir_r    [NPORT];
    logic [PW-1:0] pu_r     [NPORT];
    logic [PW-1:0] port_a_wake_enable_r;
    logic [PW-1:0] port_c_wake_enable_r;
    logic [2:0]    function_select_r;
    gpm_map_t      remap_r;
    logic [3:0]    lcd_common_ctrl_r;
    logic [PW-1:0] analog_pin_select_r;
    logic          wake_r;
    logic [NPORT*PW-1:0] sync1_r;
    logic [NPORT*PW-1:0] sync2_r;
    logic [NPORT*PW-1:0] prev_r;

    logic [PW-1:0] pin_s [NPORT];
    logic [PW-1:0] rd_val [NPORT];

    // ---------------------------------------------------------------
    // input synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '1;
            sync2_r <= '1;
            prev_r  <= '1;
        end else begin
            sync1_r <= pin_in;  // RL22
            sync2_r <= sync1_r; // RL22
            prev_r  <= sync2_r;
        end
    end

    // read value: live pin for inputs, latch for outputs
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            pin_s[p]  = sync2_r[p*PW +: PW];
            rd_val[p] = (dir_r[p] & pin_s[p]) | (~dir_r[p] & data_r[p]); // RL1 RL3
        end
    end

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    logic          wr_en;
    logic [11:0]   a12;
    logic [11:0]   grp;
    logic [2:0]    pidx;
    logic          port_ok;
    assign a12     = paddr[11:0];
    assign grp     = a12 & GRP_MSK;
    assign pidx    = a12[4:2];
    assign port_ok = (pidx < 3'(NPORT)) && (a12[1:0] == 2'h0);
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;

    function automatic logic hit_grp(input logic [11:0] g, input logic [11:0] base,
                                     input logic ok);
        return (g == base) && ok;
    endfunction

    logic mapped;
    always_comb begin
        mapped = hit_grp(grp, G_DATA, port_ok) || hit_grp(grp, G_DIR, port_ok)
              || hit_grp(grp, G_PU, port_ok) || hit_grp(grp, G_BSET, port_ok)
              || hit_grp(grp, G_BCLR, port_ok)
              || a12 == A_WAKEA || a12 == A_WAKEC || a12 == A_FSEL
              || a12 == A_REMAP || a12 == A_LCD || a12 == A_ANSEL
              || a12 == A_STAT || a12 == A_PINS;
    end
    assign pslverr = psel && penable && !mapped;

    // ---------------------------------------------------------------
    // port registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int p = 0; p < NPORT; p++) begin
                data_r[p] <= RST_ONES; // RL16
                dir_r[p]  <= RST_ONES; // RL16
                pu_r[p]   <= RST_ZERO; // RL19
            end
        end else if (wr_en && port_ok) begin
            if (grp == G_DATA) data_r[pidx] <= pwdata[PW-1:0];
            if (grp == G_DIR)  dir_r[pidx]  <= pwdata[PW-1:0];
            if (grp == G_PU)   pu_r[pidx]   <= pwdata[PW-1:0];
            // whole port read back, the bits given in pwdata changed, written to latch
            if (grp == G_BSET) data_r[pidx] <= rd_val[pidx] | pwdata[PW-1:0];  // RL17
            if (grp == G_BCLR) data_r[pidx] <= rd_val[pidx] & ~pwdata[PW-1:0]; // RL17
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_wake_enable_r <= RST_ZERO; // RL19
            port_c_wake_enable_r <= RST_ZERO; // RL19
            function_select_r    <= '0;
            remap_r              <= gpm_map_t'(RST_MAP); // RL12
            lcd_common_ctrl_r    <= '0;
            analog_pin_select_r  <= RST_ZERO;
        end else if (wr_en) begin
            if (a12 == A_WAKEA) port_a_wake_enable_r <= pwdata[PW-1:0];
            if (a12 == A_WAKEC) port_c_wake_enable_r <= pwdata[PW-1:0];
            if (a12 == A_FSEL)  function_select_r    <= pwdata[2:0];
            if (a12 == A_REMAP) remap_r              <= gpm_map_t'(pwdata[1:0]);
            if (a12 == A_LCD)   lcd_common_ctrl_r    <= pwdata[3:0];
            if (a12 == A_ANSEL) analog_pin_select_r  <= pwdata[PW-1:0];
        end
    end

    // ---------------------------------------------------------------
    // wake-up: sticky, set wins over a clearing write
    // ---------------------------------------------------------------
    logic [PW-1:0] fall_a;
    logic [PW-1:0] fall_c;
    logic          wake_evt;
    assign fall_a   = prev_r[P_A*PW +: PW] & ~pin_s[P_A] & port_a_wake_enable_r;
    assign fall_c   = prev_r[P_C*PW +: PW] & ~pin_s[P_C] & port_c_wake_enable_r;
    assign wake_evt = sleep_mode && (|fall_a || |fall_c); // RL18

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_r <= 1'b0;
        end else if (wake_evt) begin
            wake_r <= 1'b1; // RL18
        end else if (wr_en && a12 == A_STAT && pwdata[ST_WAKE]) begin
            wake_r <= 1'b0;
        end
    end
    assign wake_req = wake_r;

    // ---------------------------------------------------------------
    // remap: slot pins for divider, timer0, interrupt, timer1
    // ---------------------------------------------------------------
    logic [2:0] slot_port;
    logic [2:0] slot_bit [4];
    always_comb begin
        unique case (remap_r)
            GPM_MAP_A: begin // RL13
                slot_port = P_A;
                for (int s = 0; s < 4; s++) slot_bit[s] = 3'(1 + s);
            end
            GPM_MAP_C: begin // RL13
                slot_port = P_C;
                for (int s = 0; s < 4; s++) slot_bit[s] = 3'(5 - s);
            end
            GPM_MAP_B: begin // RL14
                slot_port = P_B;
                for (int s = 0; s < 4; s++) slot_bit[s] = 3'(s);
            end
            GPM_MAP_E: begin // RL14
                slot_port = P_E;
                for (int s = 0; s < 4; s++) slot_bit[s] = 3'(s);
            end
        endcase
    end

    function automatic logic slot_in_lvl(input logic [PW-1:0] pins,
                                         input logic [PW-1:0] dir,
                                         input logic [2:0] b);
        return pins[b] & dir[b];
    endfunction

    // function inputs come only from the mapped pin, only when it is an input
    always_comb begin
        ext_irq_level    = irq_ctrl_en
            && slot_in_lvl(pin_s[slot_port], dir_r[slot_port], slot_bit[2]); // RL4 RL21
        timer0_ext_input = timer0_count_mode
            && slot_in_lvl(pin_s[slot_port], dir_r[slot_port], slot_bit[1]); // RL6 RL21
        timer1_ext_input = timer1_count_mode
            && slot_in_lvl(pin_s[slot_port], dir_r[slot_port], slot_bit[3]); // RL6 RL21
    end

    // ---------------------------------------------------------------
    // pin drive, pull-high and analog
    // ---------------------------------------------------------------
    logic [PW-1:0] drv  [NPORT];
    logic [PW-1:0] oe   [NPORT];
    logic [PW-1:0] pu   [NPORT];
    logic [PW-1:0] ana  [NPORT];
    always_comb begin
        for (int p = 0; p < NPORT; p++) begin
            // function pins keep plain i/o when their source is not routed
            drv[p] = data_r[p];  // RL2 RL5 RL7
            oe[p]  = ~dir_r[p];  // RL2
            pu[p]  = pu_r[p] & dir_r[p]; // RL20
            ana[p] = '0;
        end
        pu[P_A] = pu[P_A] & PU_MASK_A; // RL20
        // divider routed by select bit to the slot-0 pin chosen by the remap field
        if (function_select_r[FS_PFD] && !dir_r[slot_port][slot_bit[0]]) begin
            drv[slot_port][slot_bit[0]] = freq_divider_src; // RL8 RL15
        end
        if (function_select_r[FS_PWM0] && !dir_r[P_PWM][PWM0_BIT]) begin
            drv[P_PWM][PWM0_BIT] = pwm0_src; // RL9
        end
        if (function_select_r[FS_PWM1] && !dir_r[P_PWM][PWM1_BIT]) begin
            drv[P_PWM][PWM1_BIT] = pwm1_src; // RL9
        end
        // lcd common: half bias shown as drive toggling with phase,
        // mid level left to the analog pad
        for (int k = 0; k < 4; k++) begin
            if (lcd_common_ctrl_r[k]) begin
                drv[P_B][k] = lcd_bias_phase; // RL10
                oe[P_B][k]  = 1'b1;           // RL10
                pu[P_B][k]  = 1'b0;
            end
        end
        ana[P_AN] = analog_pin_select_r;
        pu[P_AN]  = pu[P_AN] & ~analog_pin_select_r; // RL11
    end

    // registered pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out    <= '1;
            pin_oe     <= '0;
            pin_pullup <= '0;
            pin_analog <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                pin_out[p*PW +: PW]    <= drv[p];
                pin_oe[p*PW +: PW]     <= oe[p];
                pin_pullup[p*PW +: PW] <= pu[p];
                pin_analog[p*PW +: PW] <= ana[p];
            end
        end
    end

    // ---------------------------------------------------------------
    // read mux, registered in the setup cycle
    // ---------------------------------------------------------------
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = '0;
        if (port_ok) begin
            if (grp == G_DATA || grp == G_BSET || grp == G_BCLR)
                rd_nxt[PW-1:0] = rd_val[pidx]; // RL1 RL3
            if (grp == G_DIR) rd_nxt[PW-1:0] = dir_r[pidx];
            if (grp == G_PU)  rd_nxt[PW-1:0] = pu_r[pidx];
        end
        unique case (a12)
            A_WAKEA: rd_nxt[PW-1:0] = port_a_wake_enable_r;
            A_WAKEC: rd_nxt[PW-1:0] = port_c_wake_enable_r;
            A_FSEL:  rd_nxt[2:0]    = function_select_r;
            A_REMAP: rd_nxt[1:0]    = remap_r;
            A_LCD:   rd_nxt[3:0]    = lcd_common_ctrl_r;
            A_ANSEL: rd_nxt[PW-1:0] = analog_pin_select_r;
            A_STAT:  rd_nxt[ST_WAKE] = wake_r;
            default: ;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_nxt;
        end
    end
endmodule
